// File: inc/dsf_map.vh
// Purpose: constants shared by the FIFO channel and its synchroniser
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef DSF_MAP_VH
`define DSF_MAP_VH

// Register word addresses
`define DSF_REG_STATUS    4'h0
`define DSF_REG_MASK      4'h1
`define DSF_REG_FLAGS     4'h2
`define DSF_REG_LEVEL     4'h3
`define DSF_REG_EOFF      4'h4
`define DSF_REG_FOFF      4'h5

// Register bus widths
`define DSF_ADDR_W        4
`define DSF_DATA_W        16

// Event bits of status and mask
`define DSF_EV_W          6
`define DSF_EV_FULL       0
`define DSF_EV_EMPTY      1
`define DSF_EV_AFULL      2
`define DSF_EV_AEMPTY     3
`define DSF_EV_OVERFLOW   4
`define DSF_EV_UNDERFLOW  5

// Live flag bits of the flags register
`define DSF_FL_FULL       0
`define DSF_FL_EMPTY      1
`define DSF_FL_AFULL      2
`define DSF_FL_AEMPTY     3
`define DSF_FL_LOADMODE   4

// Reset and default values
`define DSF_DEF_OFFSET    18'h00007
`define DSF_MASK_RST      6'h00
`define DSF_OFF_BYTE_W    9

`endif

// File: verilog/dsf_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`include "dsf_map.vh"

module dsf_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync
);

  reg [W-1:0] stage_one;

  // No reset, so the mode strap still reaches the channel while reset is held
  always @(posedge clk_sys) begin
    stage_one <= pin_in;
    pin_sync  <= stage_one;
  end

endmodule

// File: verilog/dsf_channel.v
// Purpose: one channel of a dual synchronous 9-bit FIFO with status flags
// Assumes: pin clocks and controls are slow against clk_sys and pass a synchroniser
// Notes:   flags are active low; registers give interrupt status, mask and level
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "dsf_map.vh"

// What this block does
// [RULE1] First word appears one read edge after write, or two if edges collide.
// [RULE2] First-word latency only applies while the empty flag is low.
// [RULE3] Read edge too near a write edge defers almost-full to next write edge.
// [RULE4] Write edge too near a read edge defers almost-empty to next read edge.
// [RULE5] Almost-full goes low when a write brings the count to full minus offset.
// [RULE6] Almost-empty goes low when a read brings the count down to the offset.
// [RULE7] Shared pin low in reset selects offset load and read control.
// [RULE8] Outside logic may ground the second read enable.
// [RULE9] Outside logic combines empty and full flags for wider words.
// [RULE10] Outside logic may take almost flags from any one channel.
// [RULE11] Shared pin high in reset makes it a second write enable.
// [RULE12] As second write enable, offsets cannot load; default thresholds stay.
// [RULE13] Depth expansion logic drives one enable per port to sequence devices.
// [RULE14] Default almost-full is low within seven words of full.
// [RULE15] Default almost-empty is low at seven words or fewer.
// [RULE16] Flags active low; full pair on write edges, empty pair on read edges.
module dsf_channel #(
  parameter DEPTH = 256,
  parameter AW    = 8,
  parameter DW    = 9
) (
  input  wire                   clk_sys,
  input  wire                   rst_n,
  input  wire                   write_port_clock,
  input  wire                   read_port_clock,
  input  wire                   write_enable_one_n,
  input  wire                   write_enable_two_or_load,
  input  wire                   read_enable_one_n,
  input  wire                   second_read_enable_n,
  input  wire                   output_enable_n,
  input  wire [DW-1:0]          data_in,
  output reg  [DW-1:0]          data_out,
  output wire                   data_out_oe,
  output reg                    full_flag,
  output reg                    empty_flag,
  output reg                    almost_full_flag,
  output reg                    almost_empty_flag,
  input  wire [`DSF_ADDR_W-1:0] reg_addr,
  input  wire [`DSF_DATA_W-1:0] reg_wdata,
  input  wire                   reg_write,
  input  wire                   reg_read,
  output reg  [`DSF_DATA_W-1:0] reg_rdata,
  output wire                   irq
);

  localparam [31:0] DEPTH_W = DEPTH;
  localparam [AW:0] DEPTH_C = DEPTH_W[AW:0];
  localparam        NPIN    = DW + 7;

  // Offset load and read sequence, one-hot
  localparam [3:0] SEQ_ELSB = 4'h1;
  localparam [3:0] SEQ_EMSB = 4'h2;
  localparam [3:0] SEQ_FLSB = 4'h4;
  localparam [3:0] SEQ_FMSB = 4'h8;

  // Pin synchronisation
  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s;

  assign pin_raw = {data_in, output_enable_n, second_read_enable_n, read_enable_one_n,
                    write_enable_two_or_load, write_enable_one_n, read_port_clock,
                    write_port_clock};

  dsf_sync #(
    .W        (NPIN)
  ) u_sync (
    .clk_sys  (clk_sys),
    .pin_in   (pin_raw),
    .pin_sync (pin_s)
  );

  wire          wclk_s  = pin_s[0];
  wire          rclk_s  = pin_s[1];
  wire          wen1_s  = pin_s[2];
  wire          wen2_s  = pin_s[3];
  wire          ren1_s  = pin_s[4];
  wire          ren2_s  = pin_s[5];
  wire          oe_n_s  = pin_s[6];
  wire [DW-1:0] din_s   = pin_s[NPIN-1:7];

  reg wclk_d;
  reg rclk_d;

  wire wr_edge = wclk_s & ~wclk_d;
  wire rd_edge = rclk_s & ~rclk_d;

  // Mode strap, caught every cycle while reset is held
  reg load_mode;

  always @(posedge clk_sys) begin
    // Follow the pins through reset so a free-running clock gives no false edge
    wclk_d <= wclk_s;
    rclk_d <= rclk_s;
    if (!rst_n) begin
      load_mode <= ~wen2_s; // [RULE7] [RULE11]
    end
  end

  // Storage and pointers; one extra pointer bit tells full from empty
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW:0]   wptr;
  reg [AW:0]   rptr;
  reg [17:0]   empty_off;
  reg [17:0]   full_off;
  reg [3:0]    seq;

  // Same pin pattern writes in both modes; load only when strapped for it
  wire wr_try   = wr_edge & ~wen1_s & wen2_s;
  wire do_write = wr_try & full_flag;
  wire do_load  = wr_edge & ~wen1_s & ~wen2_s & load_mode; // [RULE7] [RULE12]
  wire rd_both  = rd_edge & ~ren1_s & ~ren2_s;
  wire rd_try   = rd_both & (wen2_s | ~load_mode);
  wire do_read  = rd_try & empty_flag; // [RULE2]
  wire do_oread = rd_both & ~wen2_s & load_mode & ~do_load;

  // Effective thresholds; outside load mode the defaults hold
  wire [17:0]   def_off = `DSF_DEF_OFFSET;
  wire [AW-1:0] n_off = load_mode ? empty_off[AW-1:0] : def_off[AW-1:0]; // [RULE12] [RULE15]
  wire [AW-1:0] m_off = load_mode ? full_off[AW-1:0] : def_off[AW-1:0];  // [RULE12] [RULE14]
  wire [AW:0]   full_thr = DEPTH_C - {1'b0, m_off};

  // Each side judges with the other pointer as last settled, so a
  // colliding edge of the other side is only seen on the next own edge
  wire [AW:0] next_wptr = do_write ? wptr + 1'b1 : wptr;
  wire [AW:0] next_rptr = do_read ? rptr + 1'b1 : rptr;
  wire [AW:0] wcount    = next_wptr - rptr; // [RULE3]
  wire [AW:0] rcount    = wptr - next_rptr; // [RULE4]

  always @(posedge clk_sys) begin
    if (do_write) begin
      mem[wptr[AW-1:0]] <= din_s;
    end
  end

  // Write side: pointer and full pair of flags
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wptr             <= {(AW+1){1'b0}};
      full_flag        <= 1'b1;
      almost_full_flag <= 1'b1;
    end else if (wr_edge) begin
      wptr             <= next_wptr;
      full_flag        <= ~(wcount == DEPTH_C);   // [RULE16]
      almost_full_flag <= ~(wcount >= full_thr);  // [RULE5] [RULE14] [RULE16]
    end
  end

  // Read side: pointer, empty pair of flags, data register
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rptr              <= {(AW+1){1'b0}};
      empty_flag        <= 1'b0;
      almost_empty_flag <= 1'b0;
      data_out          <= {DW{1'b0}};
    end else if (rd_edge) begin
      rptr              <= next_rptr;
      empty_flag        <= (rcount != {(AW+1){1'b0}}); // [RULE1] [RULE16]
      almost_empty_flag <= ~(rcount <= {1'b0, n_off}); // [RULE6] [RULE15] [RULE16]
      if (do_read) begin
        data_out <= mem[rptr[AW-1:0]]; // [RULE1]
      end else if (do_oread) begin
        case (seq)
          SEQ_ELSB: data_out <= empty_off[DW-1:0];
          SEQ_EMSB: data_out <= empty_off[17:DW];
          SEQ_FLSB: data_out <= full_off[DW-1:0];
          SEQ_FMSB: data_out <= full_off[17:DW];
          default:  data_out <= {DW{1'b0}};
        endcase
      end
    end
  end

  // Offset registers and their shared selection sequence
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      empty_off <= `DSF_DEF_OFFSET;
      full_off  <= `DSF_DEF_OFFSET;
      seq       <= SEQ_ELSB;
    end else if (do_load | do_oread) begin
      case (seq)
        SEQ_ELSB: begin
          if (do_load) begin
            empty_off[DW-1:0] <= din_s;
          end
          seq <= SEQ_EMSB;
        end
        SEQ_EMSB: begin
          if (do_load) begin
            empty_off[17:DW] <= din_s;
          end
          seq <= SEQ_FLSB;
        end
        SEQ_FLSB: begin
          if (do_load) begin
            full_off[DW-1:0] <= din_s;
          end
          seq <= SEQ_FMSB;
        end
        SEQ_FMSB: begin
          if (do_load) begin
            full_off[17:DW] <= din_s;
          end
          seq <= SEQ_ELSB;
        end
        default: seq <= SEQ_ELSB;
      endcase
    end
  end

  // Output enable follows the pin; low while the data lines are driven
  assign data_out_oe = oe_n_s;

  // Events: flag falls and refused accesses
  wire [`DSF_EV_W-1:0] ev_set;

  assign ev_set[`DSF_EV_FULL]      = wr_edge & full_flag & (wcount == DEPTH_C);
  assign ev_set[`DSF_EV_EMPTY]     = rd_edge & empty_flag & (rcount == {(AW+1){1'b0}});
  assign ev_set[`DSF_EV_AFULL]     = wr_edge & almost_full_flag & (wcount >= full_thr);
  assign ev_set[`DSF_EV_AEMPTY]    = rd_edge & almost_empty_flag
                                     & (rcount <= {1'b0, n_off});
  assign ev_set[`DSF_EV_OVERFLOW]  = wr_try & ~full_flag;
  assign ev_set[`DSF_EV_UNDERFLOW] = rd_try & ~empty_flag;

  reg  [`DSF_EV_W-1:0] status;
  reg  [`DSF_EV_W-1:0] mask;
  wire                 st_wr = reg_write & (reg_addr == `DSF_REG_STATUS);
  wire [`DSF_EV_W-1:0] st_clr = st_wr ? reg_wdata[`DSF_EV_W-1:0] : {`DSF_EV_W{1'b0}};

  // Set beats a clear landing in the same cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      status <= {`DSF_EV_W{1'b0}};
      mask   <= `DSF_MASK_RST;
    end else begin
      status <= (status & ~st_clr) | ev_set;
      if (reg_write & (reg_addr == `DSF_REG_MASK)) begin
        mask <= reg_wdata[`DSF_EV_W-1:0];
      end
    end
  end

  assign irq = |(status & mask);

  // Read data stands in the cycle after the strobe only
  wire [AW:0] level = wptr - rptr;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= {`DSF_DATA_W{1'b0}};
    end else if (reg_read) begin
      reg_rdata <= {`DSF_DATA_W{1'b0}};
      case (reg_addr)
        `DSF_REG_STATUS: reg_rdata[`DSF_EV_W-1:0] <= status;
        `DSF_REG_MASK:   reg_rdata[`DSF_EV_W-1:0] <= mask;
        `DSF_REG_FLAGS: begin
          reg_rdata[`DSF_FL_FULL]     <= full_flag;
          reg_rdata[`DSF_FL_EMPTY]    <= empty_flag;
          reg_rdata[`DSF_FL_AFULL]    <= almost_full_flag;
          reg_rdata[`DSF_FL_AEMPTY]   <= almost_empty_flag;
          reg_rdata[`DSF_FL_LOADMODE] <= load_mode;
        end
        `DSF_REG_LEVEL:  reg_rdata[AW:0] <= level;
        `DSF_REG_EOFF:   reg_rdata[AW-1:0] <= n_off;
        `DSF_REG_FOFF:   reg_rdata[AW-1:0] <= m_off;
        default:         reg_rdata <= {`DSF_DATA_W{1'b0}};
      endcase
    end else begin
      reg_rdata <= {`DSF_DATA_W{1'b0}};
    end
  end

endmodule

// File: verification/dsf_channel_asserts.sv
// Purpose: flag, data and register checks for dsf_channel
// Assumes: a pin edge acts 3 to 4 clk_sys cycles after it occurs
// Notes:   gap counters saturate so idle pins never wrap
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_channel_asserts #(
  parameter DW = 9
) (
  input wire                   clk_sys,
  input wire                   rst_n,
  input wire                   write_port_clock,
  input wire                   read_port_clock,
  input wire [DW-1:0]          data_out,
  input wire                   full_flag,
  input wire                   empty_flag,
  input wire                   almost_full_flag,
  input wire                   almost_empty_flag,
  input wire [`DSF_ADDR_W-1:0] reg_addr,
  input wire                   reg_read,
  input wire [`DSF_DATA_W-1:0] reg_rdata,
  input wire                   irq
);
  logic       wp = 1'b0;
  logic       rp = 1'b0;
  logic [3:0] wg = 4'hF;
  logic [3:0] rg = 4'hF;
  // Cycles since each pin clock rose; window kept loose for sync jitter
  always_ff @(posedge clk_sys) begin
    wp <= write_port_clock;
    rp <= read_port_clock;
    wg <= (write_port_clock && !wp) ? 4'h0 : wg + {3'h0, wg != 4'hF};
    rg <= (read_port_clock && !rp) ? 4'h0 : rg + {3'h0, rg != 4'hF};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ff; $changed(full_flag) |-> wg < 4'h6; endproperty
  a_ff: assert property (p_ff) else $error("full moved off write edge");
  property p_af; $changed(almost_full_flag) |-> wg < 4'h6; endproperty
  a_af: assert property (p_af) else $error("almost full off write edge");
  property p_ef; $changed(empty_flag) |-> rg < 4'h6; endproperty
  a_ef: assert property (p_ef) else $error("empty moved off read edge");
  property p_ae; $changed(almost_empty_flag) |-> rg < 4'h6; endproperty
  a_ae: assert property (p_ae) else $error("almost empty off read edge");
  property p_dq; $changed(data_out) |-> rg < 4'h6; endproperty
  a_dq: assert property (p_dq) else $error("data moved off read edge");
  property p_fa; !full_flag |-> !almost_full_flag; endproperty
  a_fa: assert property (p_fa) else $error("full without almost full");
  property p_ea; !empty_flag |-> !almost_empty_flag; endproperty
  a_ea: assert property (p_ea) else $error("empty without almost empty");
  property p_fl;
    reg_read && reg_addr == `DSF_REG_FLAGS |=> reg_rdata[3:0] == {$past(almost_empty_flag),
      $past(almost_full_flag), $past(empty_flag), $past(full_flag)};
  endproperty
  a_fl: assert property (p_fl) else $error("flags word wrong");
  cover property (!full_flag);
  cover property (empty_flag && !almost_empty_flag);
  cover property ($rose(irq));
endmodule
bind dsf_channel dsf_channel_asserts #(.DW(DW)) u_chk (.*);

// File: verification/dsf_port_logic.sv
// Purpose: write-side and read-side logic facing one FIFO channel
// Assumes: pin clocks idle low between transfers
// Notes:   each pin phase spans 3 or more clk_sys cycles for the synchroniser
`timescale 1ns/100ps
module dsf_port_logic (
  input  wire        clk_sys,
  output logic       write_port_clock,
  output logic       read_port_clock,
  output logic       write_enable_one_n,
  output logic       read_enable_one_n,
  output wire        second_read_enable_n,
  output logic [8:0] data_in
);
  assign second_read_enable_n = 1'b0;
  initial begin
    write_port_clock = 1'b0;
    read_port_clock = 1'b0;
    write_enable_one_n = 1'b1;
    read_enable_one_n = 1'b1;
    data_in = 9'h155;
  end
  // Data inverts once released so a stale word never looks valid
  task automatic wr(input logic en_n, input logic [8:0] d);
    @(posedge clk_sys);
    write_enable_one_n <= en_n;
    data_in <= d;
    repeat (3) @(posedge clk_sys);
    write_port_clock <= 1'b1;
    repeat (4) @(posedge clk_sys);
    write_port_clock <= 1'b0;
    write_enable_one_n <= 1'b1;
    data_in <= ~d;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rd;
    @(posedge clk_sys);
    read_enable_one_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    read_port_clock <= 1'b1;
    repeat (4) @(posedge clk_sys);
    read_port_clock <= 1'b0;
    read_enable_one_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// File: verification/dsf_channel_bench.sv
// Purpose: self-checking bench for dsf_channel
// Assumes: DEPTH cut to 16 to keep fills short
// Notes:   pin traffic from dsf_port_logic, registers from tasks here
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_channel_bench;
  localparam int DEPTH = 16;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        write_enable_two_or_load = 1'b0;
  logic        output_enable_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] rv;
  wire  [15:0] reg_rdata;
  wire  [8:0]  data_in, data_out;
  wire         write_port_clock, read_port_clock, write_enable_one_n, read_enable_one_n;
  wire         second_read_enable_n, data_out_oe, irq, full_flag, empty_flag;
  wire         almost_full_flag, almost_empty_flag;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  dsf_port_logic far (.*);
  dsf_channel #(.DEPTH(DEPTH), .AW(4), .DW(9)) dut (.*);
  // Second channel shares every control: the upper half of a wider word
  wire  [8:0]  hi_data_out;
  wire         hi_full_flag;
  wire         hi_empty_flag;
  wire         any_full_n = full_flag & hi_full_flag;
  wire         any_empty_n = empty_flag & hi_empty_flag;
  dsf_channel #(.DEPTH(DEPTH), .AW(4), .DW(9)) dut_hi (
    .clk_sys                  (clk_sys),
    .rst_n                    (rst_n),
    .write_port_clock         (write_port_clock),
    .read_port_clock          (read_port_clock),
    .write_enable_one_n       (write_enable_one_n),
    .write_enable_two_or_load (write_enable_two_or_load),
    .read_enable_one_n        (read_enable_one_n),
    .second_read_enable_n     (second_read_enable_n),
    .output_enable_n          (output_enable_n),
    .data_in                  (data_in),
    .data_out                 (hi_data_out),
    .data_out_oe              (),
    .full_flag                (hi_full_flag),
    .empty_flag               (hi_empty_flag),
    .almost_full_flag         (),
    .almost_empty_flag        (),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_write                (reg_write),
    .reg_read                 (reg_read),
    .reg_rdata                (),
    .irq                      ()
  );
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Strap held well past the capture window before release
  task automatic do_reset(input logic s);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    write_enable_two_or_load <= s;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic offs(input logic [15:0] e, input logic [15:0] f);
    reg_rd(`DSF_REG_EOFF);
    chk(rv, e);
    reg_rd(`DSF_REG_FOFF);
    chk(rv, f);
  endtask
  // Fill, drain down to the empty boundary, then one idle write edge
  task automatic run(input int n, input int m, input int cnt);
    for (int k = 1; k <= cnt; k++) begin
      far.wr(1'b0, 9'(k));
      chk(almost_full_flag, k < DEPTH - m);
      chk(full_flag, k < DEPTH);
      chk(any_full_n, k < DEPTH);
    end
    far.rd;
    chk({empty_flag, almost_empty_flag, data_out}, {1'h1, cnt > n, 9'h000});
    chk(any_empty_n, 1'b1);
    for (int k = 1; k <= cnt; k++) begin
      far.rd;
      chk(data_out, 16'(k));
      chk(hi_data_out, 16'(k));
      chk(almost_empty_flag, cnt - k > n);
    end
    chk({empty_flag, full_flag}, 16'(cnt < DEPTH));
    chk(any_empty_n, 1'b0);
    far.wr(1'b1, 9'h000);
    chk({full_flag, almost_full_flag}, 16'h0003);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    do_reset(1'b0);
    chk({full_flag, almost_full_flag, empty_flag, almost_empty_flag, irq}, 16'h0018);
    output_enable_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(data_out_oe, 1'b1);
    output_enable_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(data_out_oe, 1'b0);
    reg_rd(`DSF_REG_FLAGS);
    chk(rv & 16'h0010, 16'h0010);
    for (int i = 0; i < 4; i++) far.wr(1'b0, i[0] ? 9'h000 : 9'(2 + i / 2));
    offs(16'h0002, 16'h0003);
    @(posedge clk_sys);
    write_enable_two_or_load <= 1'b1;
    run(2, 3, DEPTH);
    $display("load mode fill and drain done");
    reg_rd(`DSF_REG_STATUS);
    chk(rv & 16'h0025, 16'h0025);
    reg_wr(`DSF_REG_MASK, 16'h0020);
    #1 chk(irq, 1'b1);
    reg_wr(`DSF_REG_STATUS, 16'h0020);
    #1 chk(irq, 1'b0);
    reg_rd(4'hF);
    chk(rv, 16'h0000);
    $display("interrupt and register test done");
    do_reset(1'b1);
    reg_rd(`DSF_REG_FLAGS);
    chk(rv & 16'h0010, 16'h0000);
    @(posedge clk_sys);
    write_enable_two_or_load <= 1'b0;
    far.wr(1'b0, 9'h001);
    reg_rd(`DSF_REG_LEVEL);
    chk(rv, 16'h0000);
    offs(16'h0007, 16'h0007);
    @(posedge clk_sys);
    write_enable_two_or_load <= 1'b1;
    run(7, 7, 9);
    $display("depth mode test done");
    give_verdict;
  end
endmodule
